/* File: dadc_ctrl.sv */
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module dadc_ctrl import dadc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core codes, offset binary
  input wire logic [9:0] raw_a,
  input wire logic [9:0] raw_b,
  // data buses
  output logic [9:0] bus_a,
  output logic [9:0] bus_b
);
  // apb and control state
  logic [CTL_W-1:0] ctl_ff, nxt_ctl;
  logic trig_prev_ff, nxt_trig_prev;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  dadc_mode_t mode_ff, nxt_mode;
  logic setup, access, mapped, trig_pulse, run, par, fmt;
  logic busy_a, busy_b;
  logic [10:0] coef_a, coef_b;
  logic [9:0] cor_a, cor_b, fmt_a, fmt_b;

  assign par = ctl_ff[CTL_BUS_SEL];
  assign fmt = ctl_ff[CTL_FMT];
  assign run = (mode_ff == DADC_RUN);
  assign setup = psel && !penable;
  assign access = psel && penable && pready_ff;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_COEF);
  assign trig_pulse = ctl_ff[CTL_TRIG] && !trig_prev_ff;

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_trig_prev = ctl_ff[CTL_TRIG];
    nxt_pready = setup;
    nxt_pslverr = setup && !mapped;
    nxt_prdata = prdata_ff;
    if (access && pwrite && paddr == REG_CTRL) begin
      nxt_ctl = pwdata[CTL_W-1:0];
    end
    if (setup) begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: nxt_prdata[CTL_W-1:0] = ctl_ff;
        REG_STAT: begin
          nxt_prdata[2:0] = mode_ff;
          nxt_prdata[STAT_BUSY_I] = busy_a;
          nxt_prdata[STAT_BUSY_Q] = busy_b;
        end
        REG_COEF: begin
          nxt_prdata[COEF_I_LSB +: 11] = coef_a;
          nxt_prdata[COEF_Q_LSB +: 11] = coef_b;
        end
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // mode follows the request bits; sleep checked first
  always_comb begin
    case (mode_ff)
      DADC_RUN, DADC_STANDBY_REQUEST, DADC_SLEEP: begin
        if (ctl_ff[CTL_SLEEP]) begin
          nxt_mode = DADC_SLEEP;
        end else if (ctl_ff[CTL_STANDBY_REQUEST]) begin
          nxt_mode = DADC_STANDBY_REQUEST;
        end else begin
          nxt_mode = DADC_RUN;
        end
      end
      default: nxt_mode = DADC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctl_ff <= CTL_RESET;
      trig_prev_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      mode_ff <= DADC_RUN;
    end else begin
      ctl_ff <= nxt_ctl;
      trig_prev_ff <= nxt_trig_prev;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      mode_ff <= nxt_mode;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // falling-edge sampler, both channels at once
  logic [9:0] samp_a_ff, samp_b_ff, nxt_samp_a, nxt_samp_b;

  always_comb begin
    nxt_samp_a = samp_a_ff;
    nxt_samp_b = samp_b_ff;
    if (run) begin
      nxt_samp_a = raw_a;
      nxt_samp_b = raw_b;
    end
  end

  always_ff @(negedge sys_clk) begin
    if (!rst_b) begin
      samp_a_ff <= 10'h000;
      samp_b_ff <= 10'h000;
    end else begin
      samp_a_ff <= nxt_samp_a;
      samp_b_ff <= nxt_samp_b;
    end
  end

  dadc_offset_cal u_cal_a (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(run),
    .start(trig_pulse),
    .raw_code(samp_a_ff),
    .cor_code(cor_a),
    .coef(coef_a),
    .busy(busy_a)
  );

  dadc_offset_cal u_cal_b (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(run),
    .start(trig_pulse),
    .raw_code(samp_b_ff),
    .cor_code(cor_b),
    .coef(coef_b),
    .busy(busy_b)
  );

  // two's complement is offset binary with the top bit inverted
  assign fmt_a = {cor_a[9] ^ fmt, cor_a[8:0]};
  assign fmt_b = {cor_b[9] ^ fmt, cor_b[8:0]};

  // rising-edge pipeline; frozen outside run so outputs keep the last result
  logic [9:0] st1_a_ff, st1_b_ff, st2_a_ff, st2_b_ff, hold_b_ff;
  logic [9:0] nxt_st1_a, nxt_st1_b, nxt_st2_a, nxt_st2_b, nxt_hold_b;
  logic [9:0] pos_a_ff, nxt_pos_a, out_b_ff, nxt_out_b;
  logic [9:0] neg_a_ff, nxt_neg_a;

  always_comb begin
    nxt_st1_a = st1_a_ff;
    nxt_st1_b = st1_b_ff;
    nxt_st2_a = st2_a_ff;
    nxt_st2_b = st2_b_ff;
    nxt_hold_b = hold_b_ff;
    nxt_pos_a = pos_a_ff;
    nxt_out_b = out_b_ff;
    if (run) begin
      nxt_st1_a = fmt_a;
      nxt_st1_b = fmt_b;
      nxt_st2_a = st1_a_ff;
      nxt_st2_b = st1_b_ff;
      nxt_hold_b = st2_b_ff;
      nxt_pos_a = st2_a_ff ^ neg_a_ff;
      nxt_out_b = par ? st2_b_ff : 10'h000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st1_a_ff <= 10'h000;
      st1_b_ff <= 10'h000;
      st2_a_ff <= 10'h000;
      st2_b_ff <= 10'h000;
      hold_b_ff <= 10'h000;
      pos_a_ff <= 10'h000;
      out_b_ff <= 10'h000;
    end else begin
      st1_a_ff <= nxt_st1_a;
      st1_b_ff <= nxt_st1_b;
      st2_a_ff <= nxt_st2_a;
      st2_b_ff <= nxt_st2_b;
      hold_b_ff <= nxt_hold_b;
      pos_a_ff <= nxt_pos_a;
      out_b_ff <= nxt_out_b;
    end
  end

  // falling half: bus a turns to channel b in multiplexed mode
  always_comb begin
    nxt_neg_a = neg_a_ff;
    if (run && !par) begin
      nxt_neg_a = hold_b_ff ^ pos_a_ff;
    end
  end

  always_ff @(negedge sys_clk) begin
    if (!rst_b) begin
      neg_a_ff <= 10'h000;
    end else begin
      neg_a_ff <= nxt_neg_a;
    end
  end

  // two-edge bus as xor of two flops: only one of them toggles per edge,
  // so no glitch, at the cost of one gate after the flops
  assign bus_a = pos_a_ff ^ neg_a_ff;
  assign bus_b = out_b_ff;

  sequence run3_s;
    $past(run, 1) && $past(run, 2) && $past(run, 3);
  endsequence

  sequence par3_s;
    $past(par, 1) && $past(par, 2) && $past(par, 3);
  endsequence

  par_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (run3_s and par3_s and (run && par)) |-> (pos_a_ff ^ neg_a_ff) == $past(fmt_a, 3))
    else $error("parallel bus a latency wrong");
  par_bus_b_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (run3_s and par3_s) |-> out_b_ff == $past(fmt_b, 3))
    else $error("parallel bus b latency wrong");
  mux_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($past(run) && !$past(par)) |-> out_b_ff == 10'h000)
    else $error("bus b not low in multiplexed mode");
  // low phase of bus a is seen at the next rising edge
  mux_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (run3_s and (run && !par)) |-> (pos_a_ff ^ neg_a_ff) == $past(fmt_b, 3))
    else $error("channel b not on bus a after falling edge");
  sleep_prio_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctl_ff[CTL_SLEEP] |=> mode_ff == DADC_SLEEP)
    else $error("sleep did not take priority");
  standby_request_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctl_ff[CTL_STANDBY_REQUEST] && !ctl_ff[CTL_SLEEP]) |=> mode_ff == DADC_STANDBY_REQUEST)
    else $error("standby not entered");
  out_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !run |=> $stable(pos_a_ff) && $stable(out_b_ff))
    else $error("outputs changed while stopped");
  fmt_msb_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run |=> st1_a_ff == ($past(fmt) ? $past(cor_a) - CODE_MID : $past(cor_a)))
    else $error("output format bit wrong");
  trig_both_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (trig_pulse && !busy_a && !busy_b) |=> busy_a && busy_b)
    else $error("correction not started in both channels");

  // apb answers with no wait state; a stretched setup phase is not supported
  sequence apb_answer_s;
    pready_ff ##1 !pready_ff;
  endsequence

  apb_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    setup |=> apb_answer_s)
    else $error("apb answer not one cycle after setup");
  apb_err_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    setup |=> pslverr_ff == !$past(mapped))
    else $error("apb error flag wrong");
  mode_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!ctl_ff[CTL_SLEEP] && !ctl_ff[CTL_STANDBY_REQUEST]) |=> mode_ff == DADC_RUN)
    else $error("run mode not entered");

  // freeze checks look at the flops; the bus pins mix both clock edges
  samp_take_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run |-> samp_a_ff == raw_a && samp_b_ff == raw_b)
    else $error("channels not sampled together");
  standby_request_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_ff == DADC_STANDBY_REQUEST |-> $stable(neg_a_ff) && $stable(samp_a_ff) && $stable(samp_b_ff))
    else $error("sampler moved in standby");
  sleep_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_ff == DADC_SLEEP |-> $stable(neg_a_ff) && $stable(samp_a_ff) && $stable(samp_b_ff))
    else $error("sampler moved in sleep");
endmodule

/* File: dadc_host_model.sv */
`timescale 1ns/1ps
module dadc_host_model import dadc_pkg::*; (
  // clock and control
  input wire logic sys_clk,
  input wire logic hold,
  // converter core codes
  output logic [9:0] raw_a,
  output logic [9:0] raw_b,
  // sampled codes, newest first
  output logic [3:0][9:0] hist_a,
  output logic [3:0][9:0] hist_b
);
  int seed = 22;
  int n = 0;
  initial begin
    raw_a = CODE_MID;
    raw_b = CODE_MID;
    hist_a = '0;
    hist_b = '0;
  end
  // steady offset codes stand in for a zero input while correcting
  always @(posedge sys_clk) begin
    n <= n + 1;
    if (hold) begin
      raw_a <= CODE_MID + 10'h005;
      raw_b <= CODE_MID - 10'h003;
    end else if (n % 8 == 0) begin
      raw_a <= (n % 16 == 0) ? CODE_MAX : 10'h000;
      raw_b <= (n % 16 == 0) ? 10'h000 : CODE_MAX;
    end else begin
      raw_a <= 10'($random(seed));
      raw_b <= 10'($random(seed));
    end
  end
  always @(negedge sys_clk) begin
    hist_a <= {hist_a[2:0], raw_a};
    hist_b <= {hist_b[2:0], raw_b};
  end
endmodule

/* File: dadc_offset_cal.sv */
`timescale 1ns/1ps
module dadc_offset_cal import dadc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic start,
  // converter code, offset binary
  input wire logic [9:0] raw_code,
  // results
  output logic [9:0] cor_code,
  output logic [10:0] coef,
  output logic busy
);
  logic [5:0] cnt_ff, nxt_cnt;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic [10:0] coef_ff, nxt_coef;
  logic [11:0] diff;
  logic [10:0] avg;

  assign avg = 11'({1'b0, acc_ff[ACC_W-1:CAL_SHIFT]}) - 11'({1'b0, CODE_MID});

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_acc = acc_ff;
    nxt_coef = coef_ff;
    if (cnt_ff == 6'h00) begin
      if (start) begin
        nxt_cnt = 6'h01;
        nxt_acc = '0;
      end
    end else if (run) begin
      // standby or sleep pauses the sequence rather than corrupting it
      if (cnt_ff <= CAL_SAMPLES) begin
        nxt_acc = acc_ff + ACC_W'(raw_code);
      end
      if (cnt_ff == CAL_CYCLES) begin
        nxt_cnt = 6'h00;
        nxt_coef = avg;
      end else begin
        nxt_cnt = cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_ff <= 6'h00;
      acc_ff <= '0;
      coef_ff <= 11'h000;
    end else begin
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      coef_ff <= nxt_coef;
    end
  end

  // subtract and clamp; range shrinks by the offset
  assign diff = {2'b00, raw_code} - {coef_ff[10], coef_ff};
  always_comb begin
    if (diff[11]) begin
      cor_code = 10'h000;
    end else if (diff[10]) begin
      cor_code = CODE_MAX;
    end else begin
      cor_code = diff[9:0];
    end
  end

  assign coef = coef_ff;
  assign busy = (cnt_ff != 6'h00);

  sequence cal_start_s;
    cnt_ff == 6'h00 && start;
  endsequence

  cal_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cal_start_s |=> cnt_ff == 6'h01 && acc_ff == '0)
    else $error("offset sequence did not start");
  cal_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (run && cnt_ff == CAL_CYCLES) |=> cnt_ff == 6'h00 && coef_ff == $past(avg))
    else $error("offset sequence end wrong");
  coef_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(run && cnt_ff == CAL_CYCLES) |=> $stable(coef_ff))
    else $error("coefficient changed outside sequence end");
  coef_reset_a: assert property (@(posedge sys_clk)
    !rst_b |=> coef_ff == 11'h000)
    else $error("coefficient not cleared");
endmodule

/* File: dadc_pkg.sv */
package dadc_pkg;
  // converter word
  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_MID = 10'h200;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  // offset correction sequence: lengths in clock cycles, shift and accumulator width in bits
  localparam logic [5:0] CAL_CYCLES = 6'h22;
  localparam logic [5:0] CAL_SAMPLES = 6'h20;
  localparam int CAL_SHIFT = 5;
  localparam int ACC_W = 15;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_COEF = 8'h08;
  // control field positions
  localparam int CTL_BUS_SEL = 0;
  localparam int CTL_FMT = 1;
  localparam int CTL_STANDBY_REQUEST = 2;
  localparam int CTL_SLEEP = 3;
  localparam int CTL_TRIG = 4;
  localparam int CTL_W = 5;
  localparam logic [4:0] CTL_RESET = 5'h01;
  // status field positions
  localparam int STAT_BUSY_I = 3;
  localparam int STAT_BUSY_Q = 4;
  // coefficient field positions
  localparam int COEF_I_LSB = 0;
  localparam int COEF_Q_LSB = 16;
  // operating modes
  typedef enum logic [2:0] {
    DADC_RUN = 3'b001,
    DADC_STANDBY_REQUEST = 3'b010,
    DADC_SLEEP = 3'b100
  } dadc_mode_t;
endpackage

/* File: dual_adc_digital_control_test.sv */
`timescale 1ns/1ps
module dual_adc_digital_control_test import dadc_pkg::*;;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic [7:0] paddr = '0;
  logic psel = 0, penable = 0, pwrite = 0, hold = 1;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [9:0] raw_a, raw_b, bus_a, bus_b;
  logic [3:0][9:0] hist_a, hist_b;
  logic bs_v = 1, fmt_v = 0, chk_on = 0;
  int n_fail = 0, compares = 0, cyc = 0, ca = 0, cb = 0, t0;

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  dadc_ctrl dadc_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_a(raw_a), .raw_b(raw_b), .bus_a(bus_a), .bus_b(bus_b));
  dadc_host_model dadc_host_model_inst (.sys_clk(sys_clk), .hold(hold), .raw_a(raw_a),
    .raw_b(raw_b), .hist_a(hist_a), .hist_b(hist_b));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  function automatic logic [9:0] expc(input logic [9:0] r, input int c, input logic f);
    int v;
    v = int'(r) - c;
    v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
    return v[9:0] ^ {f, 9'h000};
  endfunction

  // no wait count assumed; the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    check("pready setup", 0, pready);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end

  // high phase carries channel a in both modes
  always @(negedge sys_clk) begin
    if (chk_on) begin
      check("bus_a hi", expc(hist_a[2], ca, fmt_v), bus_a);
      check("bus_b", bs_v ? expc(hist_b[2], cb, fmt_v) : 10'h000, bus_b);
    end
  end
  always @(posedge sys_clk) begin
    if (chk_on) begin
      check("bus_a lo", expc(bs_v ? hist_a[3] : hist_b[3], bs_v ? ca : cb, fmt_v), bus_a);
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1;
    apb(0, REG_CTRL, 0, rd, er);
    check("ctrl reset", {27'h0, CTL_RESET}, rd);
    apb(0, REG_COEF, 0, rd, er);
    check("coef reset", 0, rd);
    apb(1, REG_CTRL, 32'h11, rd, er);
    t0 = cyc;
    apb(0, REG_STAT, 0, rd, er);
    check("busy", 32'h19, rd);
    for (int k = 0; k < 20 && rd[4:3] != 2'b00; k++) apb(0, REG_STAT, 0, rd, er);
    check("cal span", 1, (cyc - t0 >= 33 && cyc - t0 <= 40));
    apb(0, REG_COEF, 0, rd, er);
    check("coef", 32'h07fd0005, rd);
    ca = 5;
    cb = -3;
    hold <= 0;
    for (int m = 0; m < 4; m++) begin
      bs_v <= m[0];
      fmt_v <= m[1];
      apb(1, REG_CTRL, {30'h0, m[1:0]}, rd, er);
      apb(0, REG_CTRL, 0, rd, er);
      check("ctrl", {30'h0, m[1:0]}, rd);
      repeat (6) @(posedge sys_clk);
      chk_on <= 1;
      repeat (40) @(posedge sys_clk);
      chk_on <= 0;
    end
    bs_v <= 1;
    fmt_v <= 0;
    for (int k = 1; k < 4; k++) begin
      apb(1, REG_CTRL, 32'h01 | (k << 2), rd, er);
      repeat (3) @(posedge sys_clk);
      rd = {12'h0, bus_a, bus_b};
      repeat (8) @(posedge sys_clk);
      check("held", rd, {12'h0, bus_a, bus_b});
      apb(0, REG_STAT, 0, rd, er);
      check("mode", k == 1 ? DADC_STANDBY_REQUEST : DADC_SLEEP, rd);
    end
    apb(1, REG_CTRL, 32'h01, rd, er);
    repeat (6) @(posedge sys_clk);
    chk_on <= 1;
    repeat (20) @(posedge sys_clk);
    chk_on <= 0;
    apb(0, 8'h0c, 0, rd, er);
    check("unmapped err", 1, er);
    apb(1, REG_STAT, 32'hffffffff, rd, er);
    check("stat write err", 0, er);
    apb(0, REG_STAT, 0, rd, er);
    check("run mode", DADC_RUN, rd);
    end_of_test;
  end
endmodule
